// ===== logic/refs_consts.vh
`ifndef REFS_CONSTS_VH
`define REFS_CONSTS_VH
// register indices on the multiplexed bus
`define REFS_REG_A 8'h0a
`define REFS_REG_B 8'h0b
`define REFS_REG_C 8'h0c
`define REFS_REG_D 8'h0d
// rate/oscillator register fields
`define REFS_A_UIP 7
`define REFS_A_OSC_HI 6
`define REFS_A_OSC_LO 4
`define REFS_OSC_RW 3'h3
// control register fields
`define REFS_B_INHIBIT 7
`define REFS_B_PIE 6
`define REFS_B_AIE 5
`define REFS_B_UIE 4
`define REFS_B_SQUARE_WAVE_ENABLE 3
// event status fields
`define REFS_C_IRQF 7
`define REFS_C_PF 6
`define REFS_C_AF 5
`define REFS_C_UF 4
`define REFS_C_XTAL 2
// integrity status field
`define REFS_D_VALID 7
`endif

// ===== logic/refs_sync_bit.v
`timescale 1ns/1ns
`include "refs_consts.vh"
// one sticky event flag; the set beats a simultaneous clear
module refs_sync_bit (
    input wire core_clk, // clock
    input wire resetn, // async reset, low
    input wire set_pulse, // event pulse
    input wire clr_pulse, // read-clear pulse
    output reg flag_q // flag
);
    // set wins so an event at read time is kept
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flag_q <= 1'b0;
        end else if (set_pulse) begin
            flag_q <= 1'b1;
        end else if (clr_pulse) begin
            flag_q <= 1'b0;
        end
    end
endmodule

// ===== logic/refs_edge.v
`timescale 1ns/1ns
`include "refs_consts.vh"
// rising edge to one-cycle pulse
module refs_edge (
    input wire core_clk, // clock
    input wire resetn, // async reset, low
    input wire level, // level in
    output wire pulse // one-cycle pulse
);
    reg prev_q;
    // remember last level
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end
    // idle level is low, so no false edge follows reset
    assign pulse = level & ~prev_q;
endmodule

// ===== logic/refs_top.v
`timescale 1ns/1ns
`include "refs_consts.vh"
// Operation
// R1: inhibit set stops buffer transfer and clears update irq enable.
// R2: event status register is read-only to software normally.
// R3: event status bits 0, 1 and 3 always read zero.
// R4: crystal-rate enable settable only when oscillator control is 011, else cleared.
// R5: square-wave enable and crystal-rate enable drive raw crystal wave out.
// R6: update event flag sets when an update cycle completes.
// R7: alarm event flag sets on an alarm match.
// R8: periodic event flag sets once per selected periodic tick.
// R9: irq request flag sets when any flag meets its enable.
// R10: reading event status clears update, alarm, periodic and irq flags.
// R11: integrity status is read-only, bits 0 to 6 read zero.
// R12: integrity bit 7 reads backup validity.
// R13: host treats contents as untrustworthy when integrity bit reads zero.
// R14: oscillator control 011 makes event status writable.
// R15: inhibit set keeps update in progress cleared.
// R16: event flags set regardless of enables; enables gate only irq flag.
module refs_top (
    input wire core_clk, // 100 mhz core clock
    input wire resetn, // async reset, low
    input wire [7:0] bus_addr, // latched register index
    input wire [7:0] bus_wdata, // write data
    input wire bus_rd, // read strobe, one cycle
    input wire bus_wr, // write strobe, one cycle
    output reg [7:0] bus_rdata_q, // read data, registered
    input wire update_end, // update cycle end pulse
    input wire update_busy, // core update in progress level
    input wire alarm_match, // alarm match pulse
    input wire periodic_tick, // periodic tick level from divider
    input wire rate_wave, // selected square-wave level
    input wire crystal_wave, // raw crystal-rate level
    input wire backup_valid, // backup source valid level
    output wire [3:0] rate_select, // periodic rate to core divider
    output wire [2:0] oscillator_control, // oscillator pattern to core
    output wire transfer_enable, // high while buffer copy allowed
    output wire square_wave_out, // square wave pin
    output wire irq_n // interrupt pin, low active
);
    reg [2:0] osc_q;
    reg [3:0] rate_q;
    reg transfer_inhibit_q;
    reg periodic_irq_enable_q;
    reg alarm_irq_enable_q;
    reg update_irq_enable_q;
    reg square_wave_enable_q;
    reg crystal_rate_out_enable_q;
    reg [2:0] low_b_q;
    wire periodic_pulse;
    wire status_read;
    wire status_write;
    wire update_event_flag;
    wire alarm_event_flag;
    wire periodic_event_flag;
    wire irq_request_flag;
    wire irq_new;
    wire irq_held;
    wire [2:0] event_set;
    wire [2:0] event_flag;
    genvar gi;
    wire osc_rw;
    wire [7:0] status_value;
    wire [7:0] ctrl_value;
    wire [7:0] rate_value;
    wire [7:0] integ_value;

    // address decode helper shared by reads and writes
    function hit;
        input [7:0] a;
        input [7:0] r;
        begin
            hit = (a == r);
        end
    endfunction

    assign osc_rw = (osc_q == `REFS_OSC_RW);
    assign status_read = bus_rd & hit(bus_addr, `REFS_REG_C);
    // writes reach the event status only in the 011 pattern
    assign status_write = bus_wr & hit(bus_addr, `REFS_REG_C) & osc_rw; // R2 R14

    // divider tick is a level; take one pulse per period
    refs_edge u_tick (
        .core_clk(core_clk),
        .resetn(resetn),
        .level(periodic_tick),
        .pulse(periodic_pulse)
    );

    // flags ignore the enables; read clears, set wins
    assign event_set = {periodic_pulse, alarm_match, update_end}; // R6 R7 R8 R16
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
            refs_sync_bit u_flag (
                .core_clk(core_clk),
                .resetn(resetn),
                .set_pulse(event_set[gi]), // R6 R7 R8 R16
                .clr_pulse(status_read), // R10
                .flag_q(event_flag[gi])
            );
        end
    endgenerate
    assign update_event_flag = event_flag[0];
    assign alarm_event_flag = event_flag[1];
    assign periodic_event_flag = event_flag[2];

    // a new enabled event beats the read-clear, so a request is never lost
    assign irq_new = (alarm_match & alarm_irq_enable_q)
        | (periodic_pulse & periodic_irq_enable_q)
        | (update_end & update_irq_enable_q); // R9 R16
    // a flag already set when its enable is raised also requests, but yields to a read
    assign irq_held = (alarm_event_flag & alarm_irq_enable_q)
        | (periodic_event_flag & periodic_irq_enable_q)
        | (update_event_flag & update_irq_enable_q); // R9
    refs_sync_bit u_irq_request_flag (
        .core_clk(core_clk),
        .resetn(resetn),
        .set_pulse(irq_new | (irq_held & ~status_read)), // R9
        .clr_pulse(status_read), // R10
        .flag_q(irq_request_flag)
    );
    assign irq_n = ~irq_request_flag;

    // control registers
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            osc_q <= 3'h0;
            rate_q <= 4'h0;
            transfer_inhibit_q <= 1'b0;
            periodic_irq_enable_q <= 1'b0;
            alarm_irq_enable_q <= 1'b0;
            update_irq_enable_q <= 1'b0;
            square_wave_enable_q <= 1'b0;
            low_b_q <= 3'h0;
        end else begin
            if (bus_wr && hit(bus_addr, `REFS_REG_A)) begin
                osc_q <= bus_wdata[`REFS_A_OSC_HI:`REFS_A_OSC_LO];
                rate_q <= bus_wdata[3:0];
            end
            if (bus_wr && hit(bus_addr, `REFS_REG_B)) begin
                transfer_inhibit_q <= bus_wdata[`REFS_B_INHIBIT];
                periodic_irq_enable_q <= bus_wdata[`REFS_B_PIE];
                alarm_irq_enable_q <= bus_wdata[`REFS_B_AIE];
                update_irq_enable_q <= bus_wdata[`REFS_B_UIE]
                    & ~bus_wdata[`REFS_B_INHIBIT]; // R1
                square_wave_enable_q <= bus_wdata[`REFS_B_SQUARE_WAVE_ENABLE];
                low_b_q <= bus_wdata[2:0];
            end else if (transfer_inhibit_q) begin
                update_irq_enable_q <= 1'b0; // R1
            end
        end
    end

    // crystal-rate enable: only writable in the 011 pattern, cleared otherwise
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            crystal_rate_out_enable_q <= 1'b0;
        end else if (!osc_rw) begin
            crystal_rate_out_enable_q <= 1'b0; // R4
        end else if (status_write) begin
            crystal_rate_out_enable_q <= bus_wdata[`REFS_C_XTAL]; // R4 R14
        end
    end

    assign rate_select = rate_q;
    assign oscillator_control = osc_q;
    assign transfer_enable = ~transfer_inhibit_q; // R1

    // raw crystal wave takes priority over the divided rate
    assign square_wave_out = square_wave_enable_q
        & (crystal_rate_out_enable_q ? crystal_wave : rate_wave); // R5

    // status images; unused bits tied low
    assign status_value = {irq_request_flag, periodic_event_flag, alarm_event_flag,
        update_event_flag, 1'b0, crystal_rate_out_enable_q, 1'b0, 1'b0}; // R3
    assign integ_value = {backup_valid, 7'h00}; // R11 R12
    assign rate_value = {update_busy & ~transfer_inhibit_q, osc_q, rate_q}; // R15
    assign ctrl_value = {transfer_inhibit_q, periodic_irq_enable_q, alarm_irq_enable_q,
        update_irq_enable_q, square_wave_enable_q, low_b_q};

    // registered read mux; unmapped indices read zero
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bus_rdata_q <= 8'h00;
        end else if (bus_rd) begin
            case (bus_addr)
                `REFS_REG_A: bus_rdata_q <= rate_value;
                `REFS_REG_B: bus_rdata_q <= ctrl_value;
                `REFS_REG_C: bus_rdata_q <= status_value; // R10
                `REFS_REG_D: bus_rdata_q <= integ_value; // R11
                default: bus_rdata_q <= 8'h00;
            endcase
        end
    end
endmodule

// ===== sim/refs_properties.sv
`timescale 1ns/1ns
`include "refs_consts.vh"
// pin-level checks; one clock domain, so clocking and disable are shared
module refs_properties (
    input wire core_clk, // clock
    input wire resetn, // reset, low
    input wire [7:0] bus_addr, // index
    input wire bus_rd, // read
    input wire bus_wr, // write
    input wire [7:0] bus_rdata_q, // read data
    input wire update_end, // event
    input wire alarm_match, // event
    input wire periodic_tick, // tick level
    input wire backup_valid, // backup
    input wire rate_wave, // divided wave
    input wire [2:0] oscillator_control, // osc
    input wire transfer_enable, // copy allowed
    input wire square_wave_out, // pin
    input wire irq_n // pin
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // status and integrity reads, and any cause that may pull the pin low
    wire rd_c = bus_rd && bus_addr == `REFS_REG_C;
    wire rd_i = bus_rd && bus_addr == `REFS_REG_D;
    wire osc_rw = oscillator_control == `REFS_OSC_RW;
    wire cause = update_end || alarm_match || periodic_tick || bus_wr;
    // the tick reaches its flag in the same cycle as the other events; a quiet read still wants two low samples
    AST_IRQ_CLR: assert property (rd_c && !cause && !$past(periodic_tick) |=> irq_n)
        else $error("pin held after status read");
    AST_C_ZERO: assert property (rd_c |=> bus_rdata_q[3] == 1'b0 && bus_rdata_q[1:0] == 2'h0)
        else $error("status unused bits set");
    AST_D_BITS: assert property (rd_i |=> bus_rdata_q == {$past(backup_valid), 7'h00})
        else $error("integrity byte wrong");
    AST_SQW_OSC: assert property (!osc_rw && !$past(osc_rw) |-> !square_wave_out || rate_wave)
        else $error("crystal wave out without osc 011");
    AST_UIP_INH: assert property (!transfer_enable && bus_rd && bus_addr == `REFS_REG_A
        |=> !bus_rdata_q[`REFS_A_UIP])
        else $error("busy bit shown while inhibited");
    AST_UF_SET: assert property (rd_c && $past(update_end) |=> bus_rdata_q[`REFS_C_UF])
        else $error("update flag missing");
    AST_AF_SET: assert property (rd_c && $past(alarm_match) |=> bus_rdata_q[`REFS_C_AF])
        else $error("alarm flag missing");
    AST_IRQ_CAUSE: assert property ($fell(irq_n) |-> $past(cause) || $past(cause, 2))
        else $error("pin fell without cause");
    cover property ($fell(irq_n));
    cover property (!transfer_enable && bus_rd);
    cover property (osc_rw && square_wave_out);
endmodule

// ===== sim/refs_host.sv
`timescale 1ns/1ns
// host on the parallel bus; idle address and data lines carry the inverse of the last value, strobes go low
module refs_host (
    input wire core_clk, // clock
    output logic [7:0] bus_addr = 8'h00, // index
    output logic [7:0] bus_wdata = 8'h00, // data
    output logic bus_rd = 1'b0, // read
    output logic bus_wr = 1'b0 // write
);
    // one strobe edge per access, then a gap so no signal changes twice in a step
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_rd <= !w;
        bus_wr <= w;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        bus_wr <= 1'b0;
        bus_addr <= ~a;
        bus_wdata <= ~d;
        @(posedge core_clk);
    endtask
endmodule

// ===== sim/rtc_event_status_flags_tb.sv
`timescale 1ns/1ns
`include "refs_consts.vh"
module rtc_event_status_flags_tb;
    logic core_clk = 1'b0, resetn = 1'b0, update_end = 1'b0, update_busy = 1'b0;
    logic alarm_match = 1'b0, periodic_tick = 1'b0, rate_wave = 1'b0;
    logic crystal_wave = 1'b0, backup_valid = 1'b1, rd_d = 1'b0;
    wire [7:0] bus_addr, bus_wdata, bus_rdata_q;
    wire bus_rd, bus_wr, transfer_enable, square_wave_out, irq_n;
    wire [3:0] rate_select;
    wire [2:0] oscillator_control;
    logic [7:0] exp_q[$];
    logic [31:0] r = 32'h9e7c;
    int errors = 0, check_count = 0;
    refs_host h (.*);
    refs_top dut (.*);
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: saw %h want %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // note the expected byte, then read it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        h.acc(1'b0, a, 8'h00);
    endtask
    task automatic ev(input logic u, input logic a);
        update_end <= u;
        alarm_match <= a;
        @(posedge core_clk);
        update_end <= 1'b0;
        alarm_match <= 1'b0;
    endtask
    initial forever #5 core_clk = ~core_clk;
    // read data lands one edge after the strobe
    always @(posedge core_clk) begin
        if (rd_d)
            check(bus_rdata_q, exp_q.pop_front());
        rd_d <= bus_rd;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        rd(`REFS_REG_C, 8'h00);
        rd(`REFS_REG_D, 8'h80);
        backup_valid <= 1'b0;
        rd(`REFS_REG_D, 8'h00);
        rd(8'h05, 8'h00);
        // flags rise with every enable off; the pin stays quiet
        ev(1'b1, 1'b1);
        rd(`REFS_REG_C, 8'h30);
        periodic_tick <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(`REFS_REG_C, 8'h40);
        check({7'h0, irq_n}, 8'h01);
        periodic_tick <= 1'b0;
        rd(`REFS_REG_C, 8'h00);
        // enabled alarm pulls the pin until the status read
        h.acc(1'b1, `REFS_REG_B, 8'h60);
        ev(1'b0, 1'b1);
        repeat (2) @(posedge core_clk);
        check({7'h0, irq_n}, 8'h00);
        rd(`REFS_REG_C, 8'ha0);
        check({7'h0, irq_n}, 8'h01);
        h.acc(1'b1, `REFS_REG_C, 8'hff);
        rd(`REFS_REG_C, 8'h00);
        h.acc(1'b1, `REFS_REG_A, 8'h35);
        h.acc(1'b1, `REFS_REG_C, 8'h04);
        rd(`REFS_REG_C, 8'h04);
        h.acc(1'b1, `REFS_REG_B, 8'h08);
        // random rates and wave levels while the crystal output is chosen
        for (int i = 0; i < 4; i++) begin
            r = xs(r);
            crystal_wave <= r[4];
            rate_wave <= r[5];
            h.acc(1'b1, `REFS_REG_A, {4'h3, r[3:0]});
            check({4'h0, rate_select}, {4'h0, r[3:0]});
            check({7'h0, square_wave_out}, {7'h0, r[4]});
        end
        h.acc(1'b1, `REFS_REG_A, 8'h25);
        // the crystal enable drops one edge after the pattern leaves 011
        @(posedge core_clk);
        check({7'h0, square_wave_out}, {7'h0, r[5]});
        check({5'h0, oscillator_control}, 8'h02);
        rd(`REFS_REG_C, 8'h00);
        // inhibit hides the busy bit and drops the update enable
        update_busy <= 1'b1;
        h.acc(1'b1, `REFS_REG_B, 8'h90);
        check({7'h0, transfer_enable}, 8'h00);
        rd(`REFS_REG_B, 8'h80);
        rd(`REFS_REG_A, 8'h25);
        h.acc(1'b1, `REFS_REG_B, 8'h00);
        rd(`REFS_REG_A, 8'ha5);
        // let the watcher compare the last read before the verdict
        @(posedge core_clk);
        summarize();
    end
endmodule
bind refs_top refs_properties u_props (.*);
